//--- design/mem_type_pkg.sv
package mem_type_pkg;
   // memory type encodings
   localparam logic [2:0] mt_uc = 3'h0;
   localparam logic [2:0] mt_wc = 3'h1;
   localparam logic [2:0] mt_wt = 3'h4;
   localparam logic [2:0] mt_wp = 3'h5;
   localparam logic [2:0] mt_wb = 3'h6;
   localparam logic [2:0] mt_ucw = 3'h7;
   localparam int pat_entries = 8;
   localparam int pat_idx_w = 3;
   localparam int mt_w = 3;
   localparam int pte_pat_bit = 7;
   localparam int pde_pat_bit = 12;
   localparam int pcd_bit = 4;
   localparam int pwt_bit = 3;
   // default attribute table: wb, wt, weak uc, uc repeated
   localparam logic [23:0] pat_reset = 24'h1e61e6;

   typedef struct packed {
      logic [31:0] entry;
      logic large_page;
      logic is_store;
      logic [31:0] addr;
   } xlate_req_t;

   typedef struct packed {
      logic [2:0] mem_type;
      logic cacheable;
      logic spec_ok;
      logic strong_order;
   } xlate_resp_t;

   typedef enum logic [1:0] {
      order_idle,
      order_wait_rfo
   } order_state_dummy_t;
endpackage

//--- design/range_override.sv
`timescale 1ns/1ps
// one fixed uncacheable range, e.g. a legacy video window
module range_override #(
   parameter logic [31:0] base = 32'h000a0000,
   parameter logic [31:0] limit = 32'h000bffff
) (
   input wire logic [31:0] addr,
   output logic forced_uc
);
   // in-range compare, combinational only
   always_comb begin
      forced_uc = (addr >= base) && (addr <= limit);
   end
endmodule // range_override

//--- design/memory_type_resolution.sv
`timescale 1ns/1ps
module memory_type_resolution #(
   parameter int entries = mem_type_pkg::pat_entries
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic pat_wr,
   input wire logic [23:0] pat_wdata,
   output logic [23:0] page_attribute_table,
   input wire logic memory_type_range_regs,
   input wire logic global_cache_disable,
   input wire logic large_page_enable,
   input wire logic extended_phys_addr_enable,
   input wire logic req_valid,
   input wire mem_type_pkg::xlate_req_t req,
   output mem_type_pkg::xlate_resp_t resp,
   output logic resp_valid,
   input wire logic rfo_issue,
   input wire logic rfo_done,
   output logic rfo_pending,
   output logic uc_store_stall
);
   // table, answer, ordering and store tracking state
   logic [2:0] pat_q [entries];
   logic [2:0] pat_d [entries];
   logic [2:0] idx;
   logic [2:0] page_type;
   logic [2:0] type_sel;
   logic large_map;
   logic forced_uc;
   mem_type_pkg::xlate_resp_t resp_d;
   mem_type_pkg::xlate_resp_t resp_q;
   logic resp_valid_d;
   logic resp_valid_q;
   logic rfo_d;
   logic rfo_q;
   logic store_d;
   logic store_q;
   logic stall_new;
   logic stall;
   mem_type_pkg::order_state_dummy_t order_d;
   mem_type_pkg::order_state_dummy_t order_q;

   // fixed uncacheable window, honoured only while the range regs are on
   range_override u_range (
      .addr(req.addr),
      .forced_uc(forced_uc)
   );

   // table write; all eight entries loaded at once, so no entry is left stale
   // limitation: the write word is sized for eight entries only
   genvar g;
   generate
      for (g = 0; g < entries; g++) begin : g_pat
         localparam int lo = g * mem_type_pkg::mt_w;
         always_comb begin
            pat_d[g] = pat_q[g];
            if (pat_wr) begin
               pat_d[g] = pat_wdata[lo +: mem_type_pkg::mt_w];
            end
         end
         // reset fills the default table
         always_ff @(posedge clock) begin
            if (rst) begin
               pat_q[g] <= mem_type_pkg::pat_reset[lo +: mem_type_pkg::mt_w];
            end else begin
               pat_q[g] <= pat_d[g];
            end
         end
         // table output straight from the entry flops
         assign page_attribute_table[lo +: mem_type_pkg::mt_w] = pat_q[g];
      end
   endgenerate

   // index select: msb never forced to zero by paging mode
   // either paging extension allows large pages, so either one steers the msb to the pde bit
   always_comb begin
      large_map = req.large_page && (large_page_enable || extended_phys_addr_enable);
      if (large_map) begin
         idx[2] = req.entry[mem_type_pkg::pde_pat_bit];
      end else begin
         idx[2] = req.entry[mem_type_pkg::pte_pat_bit];
      end
      idx[1] = req.entry[mem_type_pkg::pcd_bit];
      idx[0] = req.entry[mem_type_pkg::pwt_bit];
      page_type = pat_q[idx];
   end

   // type priority: cache disable, then the range window, then weak uc folding
   // weak uc is folded always, so it can never reach a cached path
   always_comb begin
      type_sel = page_type;
      if (page_type == mem_type_pkg::mt_ucw) begin
         type_sel = mem_type_pkg::mt_uc;
      end
      if (memory_type_range_regs && forced_uc) begin
         type_sel = mem_type_pkg::mt_uc;
      end
      if (global_cache_disable) begin
         type_sel = mem_type_pkg::mt_uc;
      end
   end

   // attributes follow from the resolved type alone; held when idle
   always_comb begin
      resp_d = resp_q;
      resp_valid_d = req_valid;
      if (req_valid) begin
         resp_d.mem_type = type_sel;
         resp_d.cacheable = (type_sel != mem_type_pkg::mt_uc)
            && (type_sel != mem_type_pkg::mt_wc);
         resp_d.spec_ok = resp_d.cacheable
            || (type_sel == mem_type_pkg::mt_wc);
         resp_d.strong_order = (type_sel == mem_type_pkg::mt_uc);
      end
   end

   // answer registered, one cycle after the request is taken
   always_ff @(posedge clock) begin
      if (rst) begin
         resp_q <= '0;
         resp_valid_q <= 1'b0;
      end else begin
         resp_q <= resp_d;
         resp_valid_q <= resp_valid_d;
      end
   end
   // outputs straight from the flops
   assign resp = resp_q;
   assign resp_valid = resp_valid_q;

   // pending ownership request; issue wins over done in same cycle,
   // so a new txn is never lost behind the one that just ended
   always_comb begin
      rfo_d = rfo_q;
      if (rfo_done) begin
         rfo_d = 1'b0;
      end
      if (rfo_issue) begin
         rfo_d = 1'b1;
      end
   end

   // pending flag register
   always_ff @(posedge clock) begin
      if (rst) begin
         rfo_q <= 1'b0;
      end else begin
         rfo_q <= rfo_d;
      end
   end
   assign rfo_pending = rfo_q;

   // store marker for the request now being answered
   // loads never stall, only stores can overtake the ownership txn
   always_comb begin
      store_d = req_valid && req.is_store;
   end

   // lines up with resp_q, one cycle after the request
   always_ff @(posedge clock) begin
      if (rst) begin
         store_q <= 1'b0;
      end else begin
         store_q <= store_d;
      end
   end

   // uc store meeting a pending ownership txn is held, never retried
   always_comb begin
      stall_new = resp_valid_q && resp_q.strong_order && store_q && rfo_q;
   end

   // a one-cycle hold alone would let a held store slip out mid-txn,
   // so the tracker keeps it held until the txn ends
   always_comb begin
      order_d = order_q;
      case (order_q)
         mem_type_pkg::order_idle: begin
            if (stall_new) begin
               order_d = mem_type_pkg::order_wait_rfo;
            end
         end
         mem_type_pkg::order_wait_rfo: begin
            if (!rfo_q) begin
               order_d = mem_type_pkg::order_idle;
            end
         end
         default: begin
            order_d = mem_type_pkg::order_idle;
         end
      endcase
   end

   // tracker register
   always_ff @(posedge clock) begin
      if (rst) begin
         order_q <= mem_type_pkg::order_idle;
      end else begin
         order_q <= order_d;
      end
   end

   // stall is combinational from registers only, so no loop to the request side
   always_comb begin
      stall = stall_new || ((order_q == mem_type_pkg::order_wait_rfo) && rfo_q);
   end
   assign uc_store_stall = stall;
endmodule // memory_type_resolution

//--- tb/mtr_properties.sv
`timescale 1ns/1ps
// result and ordering checks, ports only
module mtr_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic pat_wr,
   input wire logic [23:0] pat_wdata,
   input wire logic [23:0] page_attribute_table,
   input wire logic memory_type_range_regs,
   input wire logic global_cache_disable,
   input wire logic req_valid,
   input wire mem_type_pkg::xlate_req_t req,
   input wire mem_type_pkg::xlate_resp_t resp,
   input wire logic resp_valid,
   input wire logic rfo_issue,
   input wire logic rfo_pending,
   input wire logic uc_store_stall
);
   localparam logic [2:0] uc = mem_type_pkg::mt_uc;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // one-cycle answer; uc results ordered, never cached nor speculated; range, table load and stall checks
   a_one_answer: assert property (resp_valid == $past(req_valid)) else $error("latency");
   a_cd_uc: assert property (req_valid && global_cache_disable |=> resp.mem_type == uc)
      else $error("cache disable");
   a_uc_ordered: assert property (resp_valid && resp.mem_type == uc |-> resp.strong_order)
      else $error("order");
   a_uc_no_spec: assert property (resp_valid && resp.mem_type == uc |->
      !resp.cacheable && !resp.spec_ok) else $error("speculation");
   a_range_uc: assert property (req_valid && memory_type_range_regs &&
      req.addr inside {[32'h000a0000:32'h000bffff]} |=> resp.mem_type == uc) else $error("range");
   a_weak_resolved: assert property (resp_valid |-> resp.mem_type != mem_type_pkg::mt_ucw)
      else $error("weak uc");
   a_table_load: assert property (pat_wr |=> page_attribute_table == $past(pat_wdata))
      else $error("load");
   a_rfo_taken: assert property (rfo_issue |=> rfo_pending) else $error("rfo");
   a_stall_cause: assert property (uc_store_stall |-> rfo_pending) else $error("stall");
   a_stall_held: assert property (uc_store_stall |=> uc_store_stall == rfo_pending)
      else $error("stall released early");
endmodule // mtr_checker
bind memory_type_resolution mtr_checker i_mtr_checker (.clock, .rst, .pat_wr, .pat_wdata,
   .page_attribute_table, .memory_type_range_regs, .global_cache_disable, .req_valid, .req,
   .resp, .resp_valid, .rfo_issue, .rfo_pending, .uc_store_stall);

//--- tb/bus_agent.sv
`timescale 1ns/1ps
// far bus agent: ownership txn, lat sets slow or prompt completion
module bus_agent (
   input wire logic clock,
   input wire logic go,
   input wire logic [3:0] lat,
   output logic rfo_issue,
   output logic rfo_done
);
   logic [3:0] cnt_q = 4'h0;
   // one issue pulse, done pulse lat cycles later
   always @(posedge clock) begin
      rfo_issue <= go;
      rfo_done <= (cnt_q == 4'h1);
      cnt_q <= go ? lat : cnt_q - 4'(cnt_q != 4'h0);
   end
endmodule // bus_agent

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0, rst = 1'b1, pat_wr = 1'b0, go = 1'b0, req_valid = 1'b0;
   logic memory_type_range_regs = 1'b0, global_cache_disable = 1'b0;
   logic large_page_enable = 1'b0, extended_phys_addr_enable = 1'b0;
   logic [3:0] lat = 4'h1;
   logic [23:0] pat_wdata = 24'h0, page_attribute_table, tbl = mem_type_pkg::pat_reset;
   logic resp_valid, rfo_issue, rfo_done, rfo_pending, uc_store_stall;
   logic [31:0] edges [4] = '{32'h0009ffff, 32'h000a0000, 32'h000bffff, 32'h000c0000};
   mem_type_pkg::xlate_req_t req = '0, r;
   mem_type_pkg::xlate_resp_t resp;
   int fail_count = 0, compares = 0, w;
   memory_type_resolution i_memory_type_resolution (.clock, .rst, .pat_wr, .pat_wdata,
      .page_attribute_table, .memory_type_range_regs, .global_cache_disable, .large_page_enable,
      .extended_phys_addr_enable, .req_valid, .req, .resp, .resp_valid, .rfo_issue, .rfo_done,
      .rfo_pending, .uc_store_stall);
   bus_agent i_bus_agent (.clock, .go, .lat, .rfo_issue, .rfo_done);
   initial forever #5 clock = ~clock;
   // cd first, then range window, weak uc folded to uc
   function automatic logic [2:0] exp_type(input mem_type_pkg::xlate_req_t q);
      logic [2:0] t;
      logic m;
      m = q.large_page & (large_page_enable | extended_phys_addr_enable);
      m = m ? q.entry[12] : q.entry[7];
      t = tbl[3 * {m, q.entry[4:3]} +: 3];
      if (global_cache_disable || t == mem_type_pkg::mt_ucw) t = mem_type_pkg::mt_uc;
      if (memory_type_range_regs && q.addr inside {[32'h000a0000:32'h000bffff]}) begin
         t = mem_type_pkg::mt_uc;
      end
      return t;
   endfunction
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic load(input logic [23:0] v);
      @(posedge clock) pat_wdata <= v;
      pat_wr <= 1'b1;
      @(posedge clock) pat_wr <= 1'b0;
      tbl = v;
      #1 check(page_attribute_table, v);
   endtask
   // one lookup; answer, attributes and stall seen one cycle after it is taken
   task automatic look(input mem_type_pkg::xlate_req_t q, input logic st);
      logic [2:0] e;
      logic [23:0] x;
      logic [23:0] y;
      @(posedge clock) req <= q;
      req_valid <= 1'b1;
      @(posedge clock) req_valid <= 1'b0;
      e = exp_type(q);
      x = 24'({st, st, 1'b1, e, e == mem_type_pkg::mt_uc,
         e != mem_type_pkg::mt_uc && e != mem_type_pkg::mt_wc, e != mem_type_pkg::mt_uc});
      #1 y = 24'({uc_store_stall, rfo_pending, resp_valid, resp.mem_type, resp.strong_order,
         resp.cacheable, resp.spec_ok});
      check(y, x);
   endtask
   initial begin
      void'($urandom(9));
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1 check(page_attribute_table, mem_type_pkg::pat_reset);
      // default table first, then random tables; window edges as corners
      for (int k = 0; k < 96; k++) begin
         if (k % 32 == 31) load(24'($urandom));
         @(posedge clock) {memory_type_range_regs, global_cache_disable, large_page_enable,
            extended_phys_addr_enable} <= {k[2], k[3] & k[4], k[1:0]};
         r = '{$urandom, k[5], 1'b0, k[6] ? edges[k % 4] : $urandom};
         look(r, 1'b0);
      end
      $display("lookup test done");
      // uc store behind slow then prompt ownership txn
      // range regs switched off the safe way: table cleared, cache disabled first
      load(24'h0);
      @(posedge clock) global_cache_disable <= 1'b1;
      @(posedge clock) memory_type_range_regs <= 1'b0;
      r.is_store = 1'b1;
      for (int s = 0; s < 2; s++) begin
         @(posedge clock) {go, lat} <= {1'b1, s ? 4'h1 : 4'h8};
         @(posedge clock) go <= 1'b0;
         @(posedge clock);
         look(r, s == 0);
         for (w = 0; rfo_pending !== 1'b0; w++) begin
            if (w > 20) fail_count++;
            if (w > 20) test_done;
            @(posedge clock) #1;
         end
      end
      $display("ordering test done");
      test_done;
   end
endmodule // tb_top
